// ===== src/art_timer_defs.vh
`ifndef ART_TIMER_DEFS_VH
`define ART_TIMER_DEFS_VH
`define ART_ADDR_COUNT 12'h000
`define ART_ADDR_RELOAD 12'h004
`define ART_ADDR_CONTROL 12'h008
`define ART_ADDR_IRQ 12'h00C
`define ART_CTRL_RESET 8'h70
`define ART_CTRL_ONES 8'h70
`define ART_CTRL_WMASK 8'h8F
`define ART_BIT_RUN 3
`define ART_BIT_OUT 7
`define ART_SEL_HI 2
`define ART_SEL_LO 0
`define ART_COUNT_MAX 8'hFF
`define ART_IRQ_REQ 0
`define ART_IRQ_EN 1
`define ART_IRQ_PLO 2
`define ART_IRQ_PHI 3
`define ART_VECTOR 16'h0026
`endif

// ===== src/art_timer.v
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "art_timer_defs.vh"

// =====================================
// resettable register stage
module art_flag_reg #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else begin
      q <= d;
    end
  end
endmodule // art_flag_reg

// =====================================
// 8-bit auto-reload timer with apb access
module art_timer (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] clkSelEnable,
  input wire irqAck,
  output reg baudTick,
  output reg irqOut,
  output reg [1:0] irqPriority,
  output reg [15:0] irqVector,
  output reg toggleFlagOut
);

  // =====================================
  // state and next values
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg [7:0] reload_q;
  reg [7:0] reload_d;
  wire [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  wire reqFlag_q;
  reg reqFlag_d;
  wire enFlag_q;
  reg enFlag_d;
  wire [1:0] prio_q;
  reg [1:0] prio_d;
  reg [31:0] rdata_d;
  reg ready_d;
  reg slverr_d;
  reg baudTick_d;
  reg irqOut_d;
  reg toggleOut_d;

  // =====================================
  // bus phase decode
  wire setupPhase;
  wire accessPhase;
  wire hitCount;
  wire hitReload;
  wire hitCtrl;
  wire hitIrq;
  wire hitAny;
  wire wrCount;
  wire wrReload;
  wire wrCtrl;
  wire wrIrq;
  wire rdSetup;

  // setup cycle, no register is written yet
  assign setupPhase = psel & ~penable;
  // access edge with ready high commits a write
  assign accessPhase = psel & penable & pready;
  assign hitCount = (paddr == `ART_ADDR_COUNT);
  assign hitReload = (paddr == `ART_ADDR_RELOAD);
  assign hitCtrl = (paddr == `ART_ADDR_CONTROL);
  assign hitIrq = (paddr == `ART_ADDR_IRQ);
  assign hitAny = hitCount | hitReload | hitCtrl | hitIrq;
  assign wrCount = accessPhase & pwrite & hitCount;
  assign wrReload = accessPhase & pwrite & hitReload;
  assign wrCtrl = accessPhase & pwrite & hitCtrl;
  assign wrIrq = accessPhase & pwrite & hitIrq;
  // read data is latched in setup, stands in access
  assign rdSetup = setupPhase & ~pwrite;

  // =====================================
  // count clock selection
  wire [2:0] selCode;
  wire selTick;
  wire running;
  wire atMax;
  wire countTick;
  wire overflow;

  // select code picks one of eight enable pulses
  assign selCode = ctrl_q[`ART_SEL_HI:`ART_SEL_LO];
  assign selTick = clkSelEnable[selCode];
  assign running = ctrl_q[`ART_BIT_RUN];
  assign atMax = (count_q == `ART_COUNT_MAX);
  assign countTick = running & selTick;
  // halted counter never overflows
  assign overflow = countTick & atMax;

  // =====================================
  // counter next value
  always @* begin
    count_d = count_q;
    if (wrCount) begin
      // software write beats a coinciding reload
      count_d = pwdata[7:0];
    end else if (overflow) begin
      count_d = reload_q;
    end else if (countTick) begin
      count_d = count_q + 8'h01;
    end
  end

  // contents undefined after reset, so no reset
  always @(posedge clk) begin
    count_q <= count_d;
  end

  // =====================================
  // reload register
  always @* begin
    reload_d = reload_q;
    if (wrCount) begin
      // counter write copies into reload too
      reload_d = pwdata[7:0];
    end else if (wrReload) begin
      reload_d = pwdata[7:0];
    end
  end

  // undefined after reset as well
  always @(posedge clk) begin
    reload_q <= reload_d;
  end

  // =====================================
  // control register
  always @* begin
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      // bits 4 to 6 stay one whatever is written
      ctrl_d = (pwdata[7:0] & `ART_CTRL_WMASK) | `ART_CTRL_ONES;
    end
    if (overflow) begin
      // toggle applies on top of a coinciding write
      ctrl_d[`ART_BIT_OUT] = ~ctrl_d[`ART_BIT_OUT];
    end
  end

  art_flag_reg #(
    .WIDTH(8),
    .RESET_VALUE(`ART_CTRL_RESET)
  ) i_art_flag_reg_ctrl (
    .clk(clk),
    .rst(rst),
    .d(ctrl_d),
    .q(ctrl_q)
  );

  // =====================================
  // interrupt request, enable and priority
  always @* begin
    reqFlag_d = reqFlag_q;
    if (overflow) begin
      // set wins over acknowledge and clear
      reqFlag_d = 1'b1;
    end else if (irqAck) begin
      reqFlag_d = 1'b0;
    end else if (wrIrq) begin
      reqFlag_d = pwdata[`ART_IRQ_REQ];
    end
  end

  always @* begin
    enFlag_d = enFlag_q;
    prio_d = prio_q;
    if (wrIrq) begin
      enFlag_d = pwdata[`ART_IRQ_EN];
      prio_d = {pwdata[`ART_IRQ_PHI], pwdata[`ART_IRQ_PLO]};
    end
  end

  art_flag_reg #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) i_art_flag_reg_req (
    .clk(clk),
    .rst(rst),
    .d(reqFlag_d),
    .q(reqFlag_q)
  );

  art_flag_reg #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) i_art_flag_reg_en (
    .clk(clk),
    .rst(rst),
    .d(enFlag_d),
    .q(enFlag_q)
  );

  art_flag_reg #(
    .WIDTH(2),
    .RESET_VALUE(2'b00)
  ) i_art_flag_reg_prio (
    .clk(clk),
    .rst(rst),
    .d(prio_d),
    .q(prio_q)
  );

  // =====================================
  // apb read data and answer
  always @* begin
    rdata_d = prdata;
    if (rdSetup) begin
      case (paddr)
        `ART_ADDR_COUNT: begin
          rdata_d = {24'h00_0000, count_q};
        end
        `ART_ADDR_RELOAD: begin
          rdata_d = {24'h00_0000, reload_q};
        end
        `ART_ADDR_CONTROL: begin
          rdata_d = {24'h00_0000, ctrl_q};
        end
        `ART_ADDR_IRQ: begin
          rdata_d = {28'h000_0000, prio_q, enFlag_q, reqFlag_q};
        end
        default: begin
          // unmapped reads return zero
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always @* begin
    // one wait-free access after every setup
    ready_d = setupPhase;
    slverr_d = setupPhase & ~hitAny;
  end

  // =====================================
  // output next values
  always @* begin
    baudTick_d = overflow;
    irqOut_d = reqFlag_q & enFlag_q;
    toggleOut_d = ctrl_q[`ART_BIT_OUT];
  end

  // =====================================
  // apb output flip-flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdata_d;
      pready <= ready_d;
      pslverr <= slverr_d;
    end
  end

  // =====================================
  // event output flip-flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      baudTick <= 1'b0;
      toggleFlagOut <= 1'b0;
    end else begin
      // one-cycle pulse per overflow
      baudTick <= baudTick_d;
      toggleFlagOut <= toggleOut_d;
    end
  end

  // =====================================
  // interrupt output flip-flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'b0;
      irqPriority <= 2'b00;
      irqVector <= 16'h0000;
    end else begin
      irqOut <= irqOut_d;
      irqPriority <= prio_q;
      // fixed vector for this overflow source
      irqVector <= `ART_VECTOR;
    end
  end

endmodule // art_timer
`default_nettype wire

// ===== test/art_timer_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// checks
module art_timer_chk(input wire logic clk, rst, psel, penable, pwrite, pready, pslverr, irqAck, baudTick,
  input wire logic irqOut, toggleFlagOut, input wire logic [11:0] paddr, input wire logic [31:0] pwdata, prdata,
  input wire logic [7:0] clkSelEnable, input wire logic [1:0] irqPriority, input wire logic [15:0] irqVector);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd = pready && !pwrite;
  wire wi = psel && penable && pwrite && paddr == 12'h00c;
  wire tk = |clkSelEnable;
  wire [1:0] pw = pwdata[3:2];
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_ctl; rd && paddr == 12'h008 |-> {prdata[31:8], prdata[6:4]} == 27'h000_0007; endproperty
  a_ctl: assert property (p_ctl) else $error("ctrl fixed bits");
  property p_vec; !$past(rst) |-> irqVector == 16'h0026; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_tgl; baudTick |=> toggleFlagOut != $past(toggleFlagOut); endproperty
  a_tgl: assert property (p_tgl) else $error("no toggle");
  property p_hld; irqOut && !(irqAck || $past(irqAck) || wi || $past(wi)) |=> irqOut; endproperty
  a_hld: assert property (p_hld) else $error("request lost");
  property p_pri; pready && pwrite && paddr == 12'h00c |-> ##2 irqPriority == $past(pw, 2); endproperty
  a_pri: assert property (p_pri) else $error("priority");
  property p_ena; rd && paddr == 12'h00c |-> !irqOut || prdata[1]; endproperty
  a_ena: assert property (p_ena) else $error("irq not enabled");
  property p_tck; baudTick |-> $past(tk); endproperty
  a_tck: assert property (p_tck) else $error("tick without count");
endmodule // art_timer_chk
bind art_timer art_timer_chk i_chk(.*);
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// bench
module tb_top;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic irqAck = 0;
  logic pready;
  logic pslverr;
  logic baudTick;
  logic irqOut;
  logic toggleFlagOut;
  logic err;
  logic bt;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [7:0] clkSelEnable = 0;
  logic [7:0] v;
  logic [1:0] irqPriority;
  logic [1:0] p;
  logic [15:0] irqVector;
  int failures = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  art_timer i_art_timer(.*);
  // control read-back, bits 4 to 6 always one
  function automatic logic [31:0] expCtrl(input logic [7:0] w);
    return {24'h00_0000, (w & 8'h8f) | 8'h70};
  endfunction
  task chk(input string n, input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // outputs change only on rising edges, so the value seen
  // at the falling edge is the one sampled at the next rise
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(negedge clk);
    while (pready !== 1'b1) @(negedge clk);
    r = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 0;
    penable <= 0;
  endtask
  task tick(input int s);
    @(posedge clk);
    clkSelEnable <= 8'(1 << s);
    @(posedge clk);
    clkSelEnable <= 0;
    @(negedge clk);
    bt = baudTick;
  endtask
  initial begin
    #50000;
    failures++;
    test_done;
  end
  initial begin
    void'($urandom(63));
    repeat (20) @(posedge clk);
    rst <= 0;
    apb(0, 12'h008, 0);
    chk("ctrl", r, 32'h0000_0070);
    v = $urandom;
    apb(1, 12'h008, v);
    apb(0, 12'h008, 0);
    chk("ctrl", r, expCtrl(v));
    apb(0, 12'h010, 0);
    chk("unmapped", r, 0);
    chk("slverr", err, 1);
    for (int s = 0; s < 8; s++) begin
      v = $urandom;
      p = $urandom;
      apb(1, 0, v);
      apb(0, 4, 0);
      chk("reload", r, v);
      apb(1, 0, 8'hfe);
      apb(1, 4, v);
      apb(1, 12'h00c, {p, 2'b10});
      apb(1, 8, 8 + s);
      tick(s);
      chk("baud", bt, 0);
      tick(s);
      chk("baud", bt, 1);
      apb(0, 0, 0);
      chk("count", r, v);
      apb(0, 8, 0);
      chk("ctrl", r, expCtrl(8'h88 + s));
      apb(0, 12'h00c, 0);
      chk("irq", r, {p, 2'b11});
      @(negedge clk);
      chk("irqOut", irqOut, 1);
      chk("prio", irqPriority, p);
      chk("flag", toggleFlagOut, 1);
      chk("vector", irqVector, 16'h0026);
      @(posedge clk);
      irqAck <= 1;
      @(posedge clk);
      irqAck <= 0;
      repeat (2) @(negedge clk);
      chk("irqOut", irqOut, 0);
    end
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    apb(0, 8, 0);
    chk("ctrl", r, 32'h0000_0070);
    apb(1, 0, 5);
    tick(0);
    apb(0, 0, 0);
    chk("count", r, 5);
    apb(1, 8, 8'h08);
    tick(0);
    apb(0, 0, 0);
    chk("count", r, 6);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
